// file: pwf_edge_if.sv
// carrier between the flag core and the wake pin edge detector
`timescale 1ns/10ps
interface pwf_edge_if #(parameter int N = 8);
	logic [N-1:0] pins_n;   // raw wake pins, asynchronous
	logic [N-1:0] func_sel; // pin acts as interrupt input
	logic [N-1:0] rise_sel; // 1 = rising edge selected
	logic [N-1:0] edge_evt; // one-cycle qualified edge

	modport detector (input pins_n, input func_sel, input rise_sel, output edge_evt);
	modport core (output pins_n, output func_sel, output rise_sel, input edge_evt);
endinterface // pwf_edge_if

// file: pwf_irq_flags.sv
// request flag registers for internal events and wake pins, AXI4-Lite slave
`timescale 1ns/10ps
// Summary of operation
// - sleep with direct transition enabled sets bit 7
// - conversion end sets bit 6
// - bit 5 reads zero, writes ignored
// - timer G capture or overflow sets bit 4
// - timer F high event sets bit 3
// - timer F low event sets bit 2
// - timer C over/underflow sets bit 1
// - async counter overflow sets bit 0
// - flags hold until software writes zero
// - wake pins 7..3 set flags on edge
// - wake pins 2..0 behave the same
// - request forwarded only while enabled
module pwf_irq_flags #(
	parameter int N_WAKE = 8
) (
	input  wire logic        I_CLK,
	input  wire logic        I_RESET,
	// AXI4-Lite slave
	input  wire logic [11:0] I_AWADDR,
	input  wire logic        I_AWVALID,
	output logic             O_AWREADY,
	input  wire logic [31:0] I_WDATA,
	input  wire logic [3:0]  I_WSTRB,
	input  wire logic        I_WVALID,
	output logic             O_WREADY,
	output logic [1:0]       O_BRESP,
	output logic             O_BVALID,
	input  wire logic        I_BREADY,
	input  wire logic [11:0] I_ARADDR,
	input  wire logic        I_ARVALID,
	output logic             O_ARREADY,
	output logic [31:0]      O_RDATA,
	output logic [1:0]       O_RRESP,
	output logic             O_RVALID,
	input  wire logic        I_RREADY,
	// peripheral event pulses, same clock
	input  wire logic        I_SLEEP_EXEC,
	input  wire logic        I_CONV_DONE,
	input  wire logic        I_TIMER_G_EVT,
	input  wire logic        I_TIMER_FH_EVT,
	input  wire logic        I_TIMER_FL_EVT,
	input  wire logic        I_TIMER_C_EVT,
	input  wire logic        I_ASYNC_OVF,
	// wake pins, active low, asynchronous
	input  wire logic [7:0]  I_WAKE_PIN_N,
	// requests toward the CPU and summary interrupt
	output logic [7:0]       O_INT_REQ,
	output logic [7:0]       O_WAKE_REQ,
	output logic             O_IRQ
);
	typedef struct packed {
		logic [11:0] aw_addr;
		logic        aw_held;
		logic [31:0] w_data;
		logic [3:0]  w_strb;
		logic        w_held;
		logic        awready;
		logic        wready;
		logic        bvalid;
		logic [1:0]  bresp;
		logic        arready;
		logic        rvalid;
		logic [1:0]  rresp;
		logic [31:0] rdata;
		logic [7:0]  int_flags;
		logic [7:0]  wake_flags;
		logic [7:0]  int_en;
		logic [7:0]  wake_en;
		logic [7:0]  wake_func;
		logic [7:0]  wake_rise;
		logic        dt_en;
		logic [15:0] irq_stat;
		logic [15:0] irq_mask;
		logic        irq;
		logic [7:0]  int_req;
		logic [7:0]  wake_req;
	} pwf_top_state_t;

	pwf_top_state_t s_r;
	pwf_top_state_t s_nxt;

	pwf_edge_if #(.N(8)) eif ();

	logic [7:0]  int_set;
	logic [7:0]  wake_set;
	logic [15:0] be;
	logic        do_wr;
	logic [31:0] rd_val;
	logic        rd_ok;

	////////////////////////////////////////////////////////////////////////
	// wake pin edge detection
	assign eif.pins_n   = I_WAKE_PIN_N;
	assign eif.func_sel = s_r.wake_func;
	assign eif.rise_sel = s_r.wake_rise;
	assign wake_set     = eif.edge_evt;

	pwf_wake_edge #(
		.N (8)
	) u_wake_edge (
		.i_clk   (I_CLK),
		.i_reset (I_RESET),
		.eif     (eif.detector)
	);

	////////////////////////////////////////////////////////////////////////
	// hardware set conditions of the internal flags
	always_comb
	begin
		int_set                   = 8'h00;
		int_set[pwf_pkg::BIT_DT]  = I_SLEEP_EXEC & s_r.dt_en;
		int_set[pwf_pkg::BIT_AD]  = I_CONV_DONE;
		int_set[pwf_pkg::BIT_TG]  = I_TIMER_G_EVT;
		int_set[pwf_pkg::BIT_TFH] = I_TIMER_FH_EVT;
		int_set[pwf_pkg::BIT_TFL] = I_TIMER_FL_EVT;
		int_set[pwf_pkg::BIT_TC]  = I_TIMER_C_EVT;
		int_set[pwf_pkg::BIT_EC]  = I_ASYNC_OVF;
	end

	////////////////////////////////////////////////////////////////////////
	// write strobe and byte lanes; write waits for address and data both
	assign do_wr = s_r.aw_held & s_r.w_held & ~s_r.bvalid;
	assign be    = {{8{s_r.w_strb[1]}}, {8{s_r.w_strb[0]}}};

	// read decode, unmapped reads answer SLVERR with zero data
	always_comb
	begin
		rd_val = 32'h00000000;
		rd_ok  = 1'b1;
		unique case ({I_ARADDR[11:2], 2'h0})
			pwf_pkg::OFS_INT_FLAGS:
				rd_val[7:0] = s_r.int_flags & pwf_pkg::INT_FLAG_MASK;
			pwf_pkg::OFS_WAKE_FLAGS:
				rd_val[7:0] = s_r.wake_flags;
			pwf_pkg::OFS_INT_EN:
				rd_val[7:0] = s_r.int_en;
			pwf_pkg::OFS_WAKE_EN:
				rd_val[7:0] = s_r.wake_en;
			pwf_pkg::OFS_WAKE_FUNC:
				rd_val[7:0] = s_r.wake_func;
			pwf_pkg::OFS_WAKE_EDGE:
				rd_val[7:0] = s_r.wake_rise;
			pwf_pkg::OFS_SYSCTL2:
				rd_val[pwf_pkg::BIT_DTEN] = s_r.dt_en;
			pwf_pkg::OFS_IRQ_STAT:
				rd_val[15:0] = s_r.irq_stat;
			pwf_pkg::OFS_IRQ_MASK:
				rd_val[15:0] = s_r.irq_mask;
			default:
				rd_ok = 1'b0;
		endcase
	end

	////////////////////////////////////////////////////////////////////////
	// next state of bus slave and registers
	always_comb
	begin
		logic [7:0]  clr8;
		logic [15:0] w1c;
		logic        hit;
		clr8  = 8'h00;
		w1c   = 16'h0000;
		hit   = 1'b1;
		s_nxt = s_r;

		// address and data channels are taken in either order
		if (I_AWVALID & s_r.awready)
		begin
			s_nxt.aw_addr = {I_AWADDR[11:2], 2'h0};
			s_nxt.aw_held = 1'b1;
		end
		if (I_WVALID & s_r.wready)
		begin
			s_nxt.w_data = I_WDATA;
			s_nxt.w_strb = I_WSTRB;
			s_nxt.w_held = 1'b1;
		end
		if (s_r.bvalid & I_BREADY)
		begin
			s_nxt.bvalid = 1'b0;
		end

		// register write decode
		if (do_wr)
		begin
			unique case (s_r.aw_addr)
				pwf_pkg::OFS_INT_FLAGS:
					clr8 = be[7:0] & ~s_r.w_data[7:0];
				pwf_pkg::OFS_WAKE_FLAGS:
					clr8 = be[7:0] & ~s_r.w_data[7:0];
				pwf_pkg::OFS_INT_EN:
					if (s_r.w_strb[0]) s_nxt.int_en = s_r.w_data[7:0];
				pwf_pkg::OFS_WAKE_EN:
					if (s_r.w_strb[0]) s_nxt.wake_en = s_r.w_data[7:0];
				pwf_pkg::OFS_WAKE_FUNC:
					if (s_r.w_strb[0]) s_nxt.wake_func = s_r.w_data[7:0];
				pwf_pkg::OFS_WAKE_EDGE:
					if (s_r.w_strb[0]) s_nxt.wake_rise = s_r.w_data[7:0];
				pwf_pkg::OFS_SYSCTL2:
					if (s_r.w_strb[0]) s_nxt.dt_en = s_r.w_data[pwf_pkg::BIT_DTEN];
				pwf_pkg::OFS_IRQ_STAT:
					w1c = be & s_r.w_data[15:0];
				pwf_pkg::OFS_IRQ_MASK:
					s_nxt.irq_mask = (s_r.irq_mask & ~be) | (s_r.w_data[15:0] & be);
				default:
					hit = 1'b0;
			endcase
			s_nxt.aw_held = 1'b0;
			s_nxt.w_held  = 1'b0;
			s_nxt.bvalid  = 1'b1;
			s_nxt.bresp   = hit ? pwf_pkg::RESP_OKAY : pwf_pkg::RESP_SLVERR;
		end

		// flags: a set in the clearing cycle wins, reserved bit stays 0
		if (do_wr && s_r.aw_addr == pwf_pkg::OFS_INT_FLAGS)
		begin
			s_nxt.int_flags = ((s_r.int_flags & ~clr8) | int_set) &
				pwf_pkg::INT_FLAG_MASK;
		end
		else
		begin
			s_nxt.int_flags = (s_r.int_flags | int_set) & pwf_pkg::INT_FLAG_MASK;
		end
		if (do_wr && s_r.aw_addr == pwf_pkg::OFS_WAKE_FLAGS)
		begin
			s_nxt.wake_flags = (s_r.wake_flags & ~clr8) | wake_set;
		end
		else
		begin
			s_nxt.wake_flags = s_r.wake_flags | wake_set;
		end

		// sticky event status, set beats write-one-to-clear
		s_nxt.irq_stat = (s_r.irq_stat & ~w1c) | {wake_set, int_set};

		// read channel: one beat, data captured at the address edge
		if (s_r.rvalid & I_RREADY)
		begin
			s_nxt.rvalid = 1'b0;
		end
		if (I_ARVALID & s_r.arready)
		begin
			s_nxt.rvalid = 1'b1;
			s_nxt.rdata  = rd_val;
			s_nxt.rresp  = rd_ok ? pwf_pkg::RESP_OKAY : pwf_pkg::RESP_SLVERR;
		end

		// each ready only while its own channel holds nothing and no response is pending, so one write and one read at a time
		s_nxt.awready = ~s_nxt.aw_held & ~s_nxt.bvalid;
		s_nxt.wready  = ~s_nxt.w_held & ~s_nxt.bvalid;
		s_nxt.arready = ~s_nxt.rvalid;

		// requests toward the CPU are gated by their enables
		s_nxt.int_req  = s_nxt.int_flags & s_nxt.int_en;
		s_nxt.wake_req = s_nxt.wake_flags & s_nxt.wake_en;
		s_nxt.irq      = |(s_nxt.irq_stat & s_nxt.irq_mask);
	end

	////////////////////////////////////////////////////////////////////////
	// state register, everything cleared at reset
	always_ff @(posedge I_CLK)
	begin
		if (I_RESET)
		begin
			s_r            <= '0;
			s_r.int_flags  <= pwf_pkg::RST_FLAGS;
			s_r.wake_flags <= pwf_pkg::RST_FLAGS;
			s_r.int_en     <= pwf_pkg::RST_CTRL;
			s_r.wake_en    <= pwf_pkg::RST_CTRL;
			s_r.wake_func  <= pwf_pkg::RST_CTRL;
			s_r.wake_rise  <= pwf_pkg::RST_CTRL;
			s_r.irq_stat   <= pwf_pkg::RST_IRQ;
			s_r.irq_mask   <= pwf_pkg::RST_IRQ;
		end
		else
		begin
			s_r <= s_nxt;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// outputs straight from the state register
	assign O_AWREADY  = s_r.awready;
	assign O_WREADY   = s_r.wready;
	assign O_BRESP    = s_r.bresp;
	assign O_BVALID   = s_r.bvalid;
	assign O_ARREADY  = s_r.arready;
	assign O_RDATA    = s_r.rdata;
	assign O_RRESP    = s_r.rresp;
	assign O_RVALID   = s_r.rvalid;
	assign O_INT_REQ  = s_r.int_req;
	assign O_WAKE_REQ = s_r.wake_req;
	assign O_IRQ      = s_r.irq;
endmodule // pwf_irq_flags

// file: pwf_irq_flags_checker.sv
// port assertions for the request flag block
`timescale 1ns/10ps
module pwf_irq_flags_checker (
	input wire logic       I_CLK,
	input wire logic       I_RESET,
	input wire logic       I_AWVALID,
	input wire logic       O_AWREADY,
	input wire logic       I_WVALID,
	input wire logic       O_WREADY,
	input wire logic       O_BVALID,
	input wire logic       I_ARVALID,
	input wire logic       O_ARREADY,
	input wire logic       O_RVALID,
	input wire logic       I_SLEEP_EXEC,
	input wire logic       I_CONV_DONE,
	input wire logic       I_TIMER_G_EVT,
	input wire logic       I_TIMER_FH_EVT,
	input wire logic       I_TIMER_FL_EVT,
	input wire logic       I_TIMER_C_EVT,
	input wire logic       I_ASYNC_OVF,
	input wire logic [7:0] O_INT_REQ,
	input wire logic       O_IRQ
);
	default clocking @(posedge I_CLK); endclocking
	default disable iff (I_RESET);
	////////////////////////////////////////////////////////////////
	// event lines in flag order; idle means no write can land next edge
	logic [7:0] evt;
	logic       idle;
	assign evt = {I_SLEEP_EXEC, I_CONV_DONE, 1'b0, I_TIMER_G_EVT,
		I_TIMER_FH_EVT, I_TIMER_FL_EVT, I_TIMER_C_EVT, I_ASYNC_OVF};
	assign idle = O_AWREADY && O_WREADY && !I_WVALID;
	////////////////////////////////////////////////////////////////
	// bus timing
	sequence s_wtake;
		I_AWVALID && O_AWREADY && I_WVALID && O_WREADY;
	endsequence
	sequence s_wdone;
		!O_BVALID && !O_AWREADY ##1 O_BVALID;
	endsequence
	AST_WRITE_LAT: assert property (s_wtake |=> s_wdone)
		else $error("write answer not two edges after take");
	AST_READ_LAT: assert property (I_ARVALID && O_ARREADY |=> O_RVALID && !O_ARREADY)
		else $error("read answer late");
	AST_ARREADY_LOW: assert property (O_RVALID |-> !O_ARREADY)
		else $error("read address taken while answer pending");
	AST_WREADY_LOW: assert property (O_BVALID |-> !O_AWREADY && !O_WREADY)
		else $error("write taken while response pending");
	////////////////////////////////////////////////////////////////
	// flags and requests
	AST_RSVD_REQ: assert property (!O_INT_REQ[5])
		else $error("reserved request set");
	AST_REQ_HOLD: assert property (idle |=> &(O_INT_REQ | ~$past(O_INT_REQ)))
		else $error("request dropped without a write");
	AST_IRQ_HOLD: assert property (idle && O_IRQ |=> O_IRQ)
		else $error("interrupt dropped without a write");
	// a request rises only after its event or after an enable write
	property p_cause(k);
		$rose(O_INT_REQ[k]) |-> $past(evt[k]) || $rose(O_BVALID);
	endproperty
	for (genvar k = 0; k < 8; k++)
	begin : g_cause
		AST_REQ_CAUSE: assert property (p_cause(k))
			else $error("request rose without an event");
	end
endmodule // pwf_irq_flags_checker

// file: pwf_irq_flags_tb.sv
// self-checking bench for the request flag block
`timescale 1ns/10ps
bind pwf_irq_flags pwf_irq_flags_checker pwf_irq_flags_checker_i (
	.I_CLK(I_CLK), .I_RESET(I_RESET), .I_AWVALID(I_AWVALID), .O_AWREADY(O_AWREADY),
	.I_WVALID(I_WVALID), .O_WREADY(O_WREADY), .O_BVALID(O_BVALID),
	.I_ARVALID(I_ARVALID), .O_ARREADY(O_ARREADY), .O_RVALID(O_RVALID),
	.I_SLEEP_EXEC(I_SLEEP_EXEC), .I_CONV_DONE(I_CONV_DONE), .I_TIMER_G_EVT(I_TIMER_G_EVT),
	.I_TIMER_FH_EVT(I_TIMER_FH_EVT), .I_TIMER_FL_EVT(I_TIMER_FL_EVT),
	.I_TIMER_C_EVT(I_TIMER_C_EVT), .I_ASYNC_OVF(I_ASYNC_OVF), .O_INT_REQ(O_INT_REQ),
	.O_IRQ(O_IRQ));
module pwf_irq_flags_tb;
	logic        clk = 1'b0;
	logic        rst = 1'b1;
	logic [11:0] awaddr = 12'h000;
	logic [11:0] araddr = 12'h000;
	logic [31:0] wdata = 32'h00000000;
	logic        awvalid = 1'b0;
	logic        wvalid = 1'b0;
	logic        bready = 1'b0;
	logic        arvalid = 1'b0;
	logic        rready = 1'b0;
	logic [6:0]  fire = 7'h00;
	logic [7:0]  pins = 8'hFF;
	logic [6:0]  evt;
	logic [7:0]  pin_n;
	logic        awready, wready, bvalid, arready, rvalid, irq;
	logic [1:0]  bresp, rresp, resp;
	logic [31:0] rdata, rdat, e;
	logic [7:0]  ereq, wreq;
	int          checks = 0;
	int          mismatches = 0;
	////////////////////////////////////////////////////////////////
	pwf_periph_model pwf_periph_model_i (.i_clk(clk),
		.i_fire(fire), .i_pins_n(pins), .o_evt(evt), .o_pins_n(pin_n));
	pwf_irq_flags pwf_irq_flags_i (.I_CLK(clk), .I_RESET(rst), .I_AWADDR(awaddr),
		.I_AWVALID(awvalid), .O_AWREADY(awready), .I_WDATA(wdata), .I_WSTRB(4'hF),
		.I_WVALID(wvalid), .O_WREADY(wready), .O_BRESP(bresp), .O_BVALID(bvalid),
		.I_BREADY(bready), .I_ARADDR(araddr), .I_ARVALID(arvalid), .O_ARREADY(arready),
		.O_RDATA(rdata), .O_RRESP(rresp), .O_RVALID(rvalid), .I_RREADY(rready),
		.I_SLEEP_EXEC(evt[6]), .I_CONV_DONE(evt[5]), .I_TIMER_G_EVT(evt[4]),
		.I_TIMER_FH_EVT(evt[3]), .I_TIMER_FL_EVT(evt[2]), .I_TIMER_C_EVT(evt[1]),
		.I_ASYNC_OVF(evt[0]), .I_WAKE_PIN_N(pin_n), .O_INT_REQ(ereq), .O_WAKE_REQ(wreq),
		.O_IRQ(irq));
	////////////////////////////////////////////////////////////////
	// clock, and a watchdog far beyond the few hundred cycles needed
	initial forever #20 clk = ~clk;
	initial
	begin
		repeat (5000) @(posedge clk);
		mismatches++;
		test_done;
	end
	////////////////////////////////////////////////////////////////
	// bus tasks: address and data offered together, held until taken
	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		logic ad;
		logic wd;
		ad = 1'b0;
		wd = 1'b0;
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		while (!(ad && wd))
		begin
			@(posedge clk);
			if (awready)
			begin
				ad = 1'b1;
				awvalid <= 1'b0;
			end
			if (wready)
			begin
				wd = 1'b1;
				wvalid <= 1'b0;
			end
		end
		do @(posedge clk); while (!bvalid);
		bready <= 1'b0;
		resp = bresp;
	endtask
	task automatic rd(input logic [11:0] a, output logic [31:0] d);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do @(posedge clk); while (!arready);
		arvalid <= 1'b0;
		do @(posedge clk); while (!rvalid);
		rready <= 1'b0;
		d = rdata;
		resp = rresp;
	endtask
	// one-cycle event from the far side, then let it land
	task automatic pulse(input int i);
		fire[i] <= 1'b1;
		@(posedge clk);
		fire <= 7'h00;
		repeat (3) @(posedge clk);
	endtask
	task automatic chk(input logic [31:0] g, input logic [31:0] x);
		checks++;
		if (g !== x)
		begin
			mismatches++;
			$display("BAD t=%0t got=%h exp=%h", $time, g, x);
		end
	endtask
	task automatic test_done;
		$display("checks=%0d mismatches=%0d", checks, mismatches);
		if (mismatches == 0 && checks > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	////////////////////////////////////////////////////////////////
	// tests
	initial
	begin
		repeat (4) @(posedge clk);
		rst <= 1'b0;
		repeat (2) @(posedge clk);
		rd(pwf_pkg::OFS_INT_FLAGS, rdat);
		chk(rdat, 32'h00000000);
		rd(pwf_pkg::OFS_WAKE_FLAGS, rdat);
		chk(rdat, 32'h00000000);
		rd(12'h024, rdat);
		chk({30'h0, resp}, {30'h0, pwf_pkg::RESP_SLVERR});
		wr(12'h024, 32'h000000FF);
		chk({30'h0, resp}, {30'h0, pwf_pkg::RESP_SLVERR});
		$display("test reset done");
		wr(pwf_pkg::OFS_INT_EN, 32'h000000FF);
		chk({30'h0, resp}, {30'h0, pwf_pkg::RESP_OKAY});
		pulse(6);
		rd(pwf_pkg::OFS_INT_FLAGS, rdat);
		chk(rdat, 32'h00000000);
		wr(pwf_pkg::OFS_SYSCTL2, 32'h00000001);
		e = 32'h00000000;
		for (int i = 0; i < 7; i++)
		begin
			pulse(i);
			e[(i >= 5) ? i + 1 : i] = 1'b1;
			rd(pwf_pkg::OFS_INT_FLAGS, rdat);
			chk(rdat, e);
		end
		chk({24'h0, ereq}, 32'h000000DF);
		wr(pwf_pkg::OFS_INT_FLAGS, 32'h000000FF);
		rd(pwf_pkg::OFS_INT_FLAGS, rdat);
		chk(rdat, 32'h000000DF);
		wr(pwf_pkg::OFS_INT_FLAGS, 32'h000000EF);
		rd(pwf_pkg::OFS_INT_FLAGS, rdat);
		chk(rdat, 32'h000000CF);
		// timer G event reaches the core exactly on the clearing edge
		fork
			wr(pwf_pkg::OFS_INT_FLAGS, 32'h00000000);
			begin
				fire[4] <= 1'b1;
				@(posedge clk);
				fire <= 7'h00;
			end
		join
		rd(pwf_pkg::OFS_INT_FLAGS, rdat);
		chk(rdat, 32'h00000010);
		wr(pwf_pkg::OFS_INT_EN, 32'h00000000);
		chk({24'h0, ereq}, 32'h00000000);
		$display("test internal done");
		// status stays sticky; only the mask gates the line
		wr(pwf_pkg::OFS_IRQ_MASK, 32'h00000000);
		repeat (2) @(posedge clk);
		chk({31'h0, irq}, 32'h00000000);
		wr(pwf_pkg::OFS_IRQ_MASK, 32'h0000FFFF);
		repeat (2) @(posedge clk);
		chk({31'h0, irq}, 32'h00000001);
		rd(pwf_pkg::OFS_IRQ_STAT, rdat);
		chk(rdat, 32'h000000DF);
		wr(pwf_pkg::OFS_IRQ_STAT, 32'h0000FFFF);
		repeat (2) @(posedge clk);
		chk({31'h0, irq}, 32'h00000000);
		$display("test interrupt done");
		// low four pins act as inputs on the falling edge first, then all eight on rising
		wr(pwf_pkg::OFS_WAKE_EN, 32'h000000FF);
		wr(pwf_pkg::OFS_WAKE_FUNC, 32'h0000000F);
		wr(pwf_pkg::OFS_WAKE_EDGE, 32'h00000000);
		pins <= 8'h00;
		repeat (10) @(posedge clk);
		rd(pwf_pkg::OFS_WAKE_FLAGS, rdat);
		chk(rdat, 32'h0000000F);
		// the unselected edge is ignored: pins rise while falling is selected
		wr(pwf_pkg::OFS_WAKE_FLAGS, 32'h00000000);
		wr(pwf_pkg::OFS_WAKE_FUNC, 32'h000000FF);
		pins <= 8'hFF;
		repeat (10) @(posedge clk);
		rd(pwf_pkg::OFS_WAKE_FLAGS, rdat);
		chk(rdat, 32'h00000000);
		wr(pwf_pkg::OFS_WAKE_EDGE, 32'h000000FF);
		pins <= 8'h00;
		repeat (10) @(posedge clk);
		pins <= 8'hFF;
		repeat (10) @(posedge clk);
		rd(pwf_pkg::OFS_WAKE_FLAGS, rdat);
		chk(rdat, 32'h000000FF);
		chk({24'h0, wreq}, 32'h000000FF);
		wr(pwf_pkg::OFS_WAKE_EN, 32'h0000000F);
		chk({24'h0, wreq}, 32'h0000000F);
		wr(pwf_pkg::OFS_WAKE_FLAGS, 32'h00000000);
		rd(pwf_pkg::OFS_WAKE_FLAGS, rdat);
		chk(rdat, 32'h00000000);
		$display("test wake done");
		test_done;
	end
endmodule // pwf_irq_flags_tb

// file: pwf_periph_model.sv
// far-side peripheral event sources and wake pin drivers
`timescale 1ns/10ps
module pwf_periph_model (
	input  wire logic       i_clk,
	input  wire logic [6:0] i_fire,
	input  wire logic [7:0] i_pins_n,
	output logic      [6:0] o_evt = 7'h00,
	output logic      [7:0] o_pins_n = 8'hFF
);
	////////////////////////////////////////////////////////////////
	// events launch off the clock like real timers, one cycle per fire
	always_ff @(posedge i_clk)
	begin
		o_evt    <= i_fire;
		o_pins_n <= i_pins_n; // pins pulled high when idle
	end
endmodule // pwf_periph_model

// file: pwf_pkg.sv
// constants shared by the wakeup and peripheral request flag block
package pwf_pkg;
	// register byte offsets on the AXI4-Lite slave
	localparam logic [11:0] OFS_INT_FLAGS  = 12'h000; // internal_event_request_flags
	localparam logic [11:0] OFS_WAKE_FLAGS = 12'h004; // wakeup_pin_request_flags
	localparam logic [11:0] OFS_INT_EN     = 12'h008; // internal_event_enable_reg
	localparam logic [11:0] OFS_WAKE_EN    = 12'h00C; // wakeup request enables
	localparam logic [11:0] OFS_WAKE_FUNC  = 12'h010; // pin acts as interrupt input
	localparam logic [11:0] OFS_WAKE_EDGE  = 12'h014; // 1 = rising edge, 0 = falling
	localparam logic [11:0] OFS_SYSCTL2    = 12'h018; // system_control_two
	localparam logic [11:0] OFS_IRQ_STAT   = 12'h01C; // sticky event status, write 1 clears
	localparam logic [11:0] OFS_IRQ_MASK   = 12'h020; // event mask, same layout

	// bit positions in internal_event_request_flags
	localparam int BIT_DT   = 7; // direct_transition_flag
	localparam int BIT_AD   = 6; // conversion_done_flag
	localparam int BIT_RSVD = 5; // reserved, reads 0
	localparam int BIT_TG   = 4; // timer_g_event_flag
	localparam int BIT_TFH  = 3; // timer_f_high_event_flag
	localparam int BIT_TFL  = 2; // timer_f_low_event_flag
	localparam int BIT_TC   = 1; // timer_c_event_flag
	localparam int BIT_EC   = 0; // async_counter_overflow_flag
	localparam int BIT_DTEN = 0; // direct_transition_enable in system_control_two

	// implemented bits of the internal flag register
	localparam logic [7:0] INT_FLAG_MASK = 8'hDF;

	// reset values
	localparam logic [7:0]  RST_FLAGS = 8'h00;
	localparam logic [7:0]  RST_CTRL  = 8'h00;
	localparam logic [15:0] RST_IRQ   = 16'h0000;
	localparam logic [7:0]  RST_PINS  = 8'hFF; // wake pins idle high

	// AXI responses
	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// file: pwf_wake_edge.sv
// wake pin synchroniser and selected-edge detector
`timescale 1ns/10ps
module pwf_wake_edge #(
	parameter int N = 8
) (
	input  wire logic   i_clk,
	input  wire logic   i_reset,
	pwf_edge_if.detector eif
);
	typedef struct packed {
		logic [N-1:0] s1;  // first stage, read only by s2
		logic [N-1:0] s2;
		logic [N-1:0] s3;
		logic [N-1:0] lvl; // filtered pin level
		logic [N-1:0] evt;
	} pwf_edge_state_t;

	pwf_edge_state_t st_r;
	pwf_edge_state_t st_nxt;
	logic [N-1:0]    lvl_new;
	logic [N-1:0]    hit;

	////////////////////////////////////////////////////////////////////////
	// per pin: level moves once stages two and three agree
	genvar g;
	generate
		for (g = 0; g < N; g++)
		begin : g_pin
			assign lvl_new[g] = (st_r.s2[g] == st_r.s3[g]) ? st_r.s2[g] : st_r.lvl[g];
			// only a pin configured as interrupt input reports its edge
			assign hit[g] = eif.func_sel[g] & (lvl_new[g] != st_r.lvl[g]) &
				(lvl_new[g] == eif.rise_sel[g]);
		end
	endgenerate

	////////////////////////////////////////////////////////////////////////
	// next state
	always_comb
	begin
		st_nxt     = st_r;
		st_nxt.s1  = eif.pins_n;
		st_nxt.s2  = st_r.s1;
		st_nxt.s3  = st_r.s2;
		st_nxt.lvl = lvl_new;
		st_nxt.evt = hit;
	end

	// state register
	always_ff @(posedge i_clk)
	begin
		if (i_reset)
		begin
			st_r <= '{s1: {N{1'b1}}, s2: {N{1'b1}}, s3: {N{1'b1}}, lvl: {N{1'b1}},
				evt: '0};
		end
		else
		begin
			st_r <= st_nxt;
		end
	end

	assign eif.edge_evt = st_r.evt;
endmodule // pwf_wake_edge
